// file: serial_status_pkg.sv
package serial_status_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] STATUS_OFS   = 12'h000;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h004;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h008;

    // ****************************************
    // serial_status fields
    // ****************************************
    localparam int TDE_BIT  = 7;
    localparam int RDF_BIT  = 6;
    localparam int ORE_BIT  = 5;
    localparam int FRE_BIT  = 4;
    localparam int PAE_BIT  = 3;
    localparam int TX_END_BIT = 2;
    localparam int RMP_BIT  = 1;
    localparam int TMP_BIT  = 0;

    localparam logic [7:0] STATUS_RESET = 8'h84;

    // ****************************************
    // interrupt status / mask fields
    // ****************************************
    localparam int IRQ_W        = 4;
    localparam int IRQ_TXE_BIT  = 0;
    localparam int IRQ_RXF_BIT  = 1;
    localparam int IRQ_ERR_BIT  = 2;
    localparam int IRQ_TX_END_BIT = 3;

    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [31:0]      ZERO_WORD = 32'h0000_0000;
endpackage : serial_status_pkg

// file: read_armed_flag.sv
`timescale 1ns/1ps
module read_armed_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // controls
    input  wire logic init,
    input  wire logic set,
    input  wire logic hw_clear,
    input  wire logic rd_one,
    input  wire logic wr_zero,
    // state
    output logic      flag,
    output logic      armed
);
    logic next_flag;
    logic sw_clear;

    // a written zero counts only after a read that returned one
    assign sw_clear = wr_zero & armed;

    // init wins over set, set wins over both clears
    always_comb begin
        if (init) begin
            next_flag = RESET_VAL;
        end else if (set) begin
            next_flag = 1'b1;
        end else if (sw_clear | hw_clear) begin
            next_flag = 1'b0;
        end else begin
            next_flag = flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= RESET_VAL;
        end else begin
            flag <= next_flag;
        end
    end

    // record of a one read, dropped once the flag clears or a zero is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
        end else begin
            armed <= next_flag & ~wr_zero & ~init & (armed | (rd_one & flag));
        end
    end
endmodule : read_armed_flag

// file: serial_status_flag_logic.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - status starts as 84 hex, reset or standby
// - ones ignored; zero clears only after one read
// - transmit-end and received mp bit read-only
// - tx empty set by reset, disable, load
// - rx full on clean char; cleared three ways
// - errors, receive disable keep data and full
// - char while full: overrun, old data kept
// - error flags stop receive; sync stops transmit
// - async framing: first stop bit zero
// - framing or parity: load data, no full
// - async parity mismatch sets parity error
// - receive disable keeps error flags
// - transmit-end set by reset, disable, last bit
// - qualified tx empty clear clears transmit-end
// - async mp format captures received mp bit
// - receive disable keeps received mp bit
// - mp wait: skip chars until mp one
// - bit zero holds transmitted mp bit
module serial_status_flag_logic
    import serial_status_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // mode and enables
    input  wire logic              standby,
    input  wire logic              transmit_enable,
    input  wire logic              receive_enable,
    input  wire logic              sync_mode,
    input  wire logic              multiproc_format,
    input  wire logic              parity_enable,
    input  wire logic              parity_odd,
    input  wire logic              multiproc_int_enable,
    output logic                   multiproc_int_enable_clear,
    // transmit path
    input  wire logic              tx_load,
    input  wire logic              tx_last_bit,
    output logic                   tx_multiproc_bit,
    output logic                   tx_blocked,
    // receive path
    input  wire logic              rx_done,
    input  wire logic [7:0]        rx_char,
    input  wire logic              rx_parity_bit,
    input  wire logic              rx_stop_bit,
    input  wire logic              rx_mp_bit,
    input  wire logic              dma_rx_read,
    output logic      [7:0]        rx_holding_reg,
    output logic                   rx_blocked,
    // interrupt
    output logic                   irq
);
    // ****************************************
    // elaboration check
    // ****************************************
    if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr
        $error("ADDR_W must lie between 4 and 12");
    end

    // ****************************************
    // apb decode
    // ****************************************
    logic              access;
    logic              rd_acc;
    logic              wr_acc;
    logic [11:0]       addr;
    logic              hit_status;
    logic              hit_istat;
    logic              hit_imask;
    logic              mapped;

    assign addr       = 12'(paddr);
    assign hit_status = (addr == STATUS_OFS);
    assign hit_istat  = (addr == IRQ_STAT_OFS);
    assign hit_imask  = (addr == IRQ_MASK_OFS);
    assign mapped     = hit_status | hit_istat | hit_imask;
    assign access     = psel & penable;
    assign rd_acc     = access & ~pwrite;
    assign wr_acc     = access & pwrite;
    assign pready     = 1'b1;
    assign pslverr    = access & ~mapped;

    // ****************************************
    // status register state
    // ****************************************
    logic [7:0]       status;
    logic [4:0]       cl_flag;
    logic [4:0]       cl_armed;
    logic [4:0]       cl_set;
    logic [4:0]       cl_hw_clear;
    logic [4:0]       cl_init;
    logic [4:0]       cl_rd_one;
    logic [4:0]       cl_wr_zero;
    logic             st_rd;
    logic             st_wr;
    logic             tx_end;
    logic             rx_mp;
    logic             any_err;
    logic             init;

    assign init  = standby;
    assign st_rd = rd_acc & hit_status;
    assign st_wr = wr_acc & hit_status;

    // ****************************************
    // receive qualification
    // ****************************************
    logic             mp_wait;
    logic             rx_take;
    logic             rx_skip;
    logic             fer_hit;
    logic             per_hit;
    logic             ore_hit;
    logic             rx_clean;

    assign any_err  = cl_flag[2] | cl_flag[1] | cl_flag[0];
    assign rx_blocked = any_err;
    assign tx_blocked = sync_mode & any_err;

    // multiprocessor wait only counts in async multiprocessor format
    assign mp_wait  = multiproc_int_enable & ~sync_mode & multiproc_format;
    assign rx_take  = rx_done & receive_enable & ~any_err;
    assign rx_skip  = mp_wait & ~rx_mp_bit;
    assign ore_hit  = rx_take & ~rx_skip & cl_flag[3];
    assign fer_hit  = rx_take & ~rx_skip & ~cl_flag[3] & ~sync_mode
                      & ~rx_stop_bit;
    assign per_hit  = rx_take & ~rx_skip & ~cl_flag[3] & ~sync_mode
                      & parity_enable
                      & ((^{rx_char, rx_parity_bit}) != parity_odd);
    assign rx_clean = rx_take & ~rx_skip & ~cl_flag[3] & ~fer_hit & ~per_hit;

    // ****************************************
    // clearable flags: 4 tde, 3 rdf, 2 ore, 1 fre, 0 pae
    // ****************************************
    assign cl_set[4]      = ~transmit_enable | tx_load;
    assign cl_set[3]      = rx_clean;
    assign cl_set[2]      = ore_hit;
    assign cl_set[1]      = fer_hit;
    assign cl_set[0]      = per_hit;
    assign cl_hw_clear[4] = 1'b0;
    assign cl_hw_clear[3] = dma_rx_read;
    assign cl_hw_clear[2] = 1'b0;
    assign cl_hw_clear[1] = 1'b0;
    assign cl_hw_clear[0] = 1'b0;
    assign cl_init        = {5{init}};

    // register bit of each clearable flag, in cell order
    assign cl_rd_one  = {5{st_rd}};
    assign cl_wr_zero = {5{st_wr}} & ~{pwdata[TDE_BIT], pwdata[RDF_BIT],
                        pwdata[ORE_BIT], pwdata[FRE_BIT], pwdata[PAE_BIT]};

    // tx empty is the only clearable flag that starts at one
    read_armed_flag #(
        .RESET_VAL (1'b1)
    ) u_tde (
        .pclk      (pclk),
        .presetn   (presetn),
        .init      (cl_init[4]),
        .set       (cl_set[4]),
        .hw_clear  (cl_hw_clear[4]),
        .rd_one    (cl_rd_one[4]),
        .wr_zero   (cl_wr_zero[4]),
        .flag      (cl_flag[4]),
        .armed     (cl_armed[4])
    );

    // one cell per receive flag
    for (genvar i = 0; i < 4; i++) begin : g_rx_flag
        read_armed_flag #(
            .RESET_VAL (1'b0)
        ) u_flag (
            .pclk      (pclk),
            .presetn   (presetn),
            .init      (cl_init[i]),
            .set       (cl_set[i]),
            .hw_clear  (cl_hw_clear[i]),
            .rd_one    (cl_rd_one[i]),
            .wr_zero   (cl_wr_zero[i]),
            .flag      (cl_flag[i]),
            .armed     (cl_armed[i])
        );
    end

    // ****************************************
    // transmit end and multiprocessor bits
    // ****************************************
    logic tde_sw_clear;

    assign tde_sw_clear = cl_wr_zero[4] & cl_armed[4];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_end <= STATUS_RESET[TX_END_BIT];
        end else if (init) begin
            tx_end <= STATUS_RESET[TX_END_BIT];
        end else if (~transmit_enable | (tx_last_bit & cl_flag[4])) begin
            tx_end <= 1'b1;
        end else if (tde_sw_clear) begin
            tx_end <= 1'b0;
        end
    end

    // only received characters and standby move the mp bit, writes never do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_mp <= STATUS_RESET[RMP_BIT];
        end else if (init) begin
            rx_mp <= STATUS_RESET[RMP_BIT];
        end else if (rx_take & ~rx_skip & ~sync_mode & multiproc_format) begin
            rx_mp <= rx_mp_bit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_multiproc_bit <= STATUS_RESET[TMP_BIT];
        end else if (init) begin
            tx_multiproc_bit <= STATUS_RESET[TMP_BIT];
        end else if (st_wr) begin
            tx_multiproc_bit <= pwdata[TMP_BIT];
        end
    end

    // leaving the mp wait on a character carrying mp one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            multiproc_int_enable_clear <= 1'b0;
        end else begin
            multiproc_int_enable_clear <= rx_take & mp_wait & rx_mp_bit;
        end
    end

    // ****************************************
    // receive holding register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_holding_reg <= 8'h00;
        end else if (rx_take & ~rx_skip & ~cl_flag[3]) begin
            rx_holding_reg <= rx_char;
        end
    end

    assign status = {cl_flag[4], cl_flag[3], cl_flag[2], cl_flag[1],
                     cl_flag[0], tx_end, rx_mp, tx_multiproc_bit};

    // ****************************************
    // interrupts
    // ****************************************
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_ev;
    logic             tde_q;
    logic             tx_end_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tde_q  <= 1'b1;
            tx_end_q <= 1'b1;
        end else begin
            tde_q  <= cl_flag[4];
            tx_end_q <= tx_end;
        end
    end

    assign irq_ev[IRQ_TXE_BIT]  = cl_flag[4] & ~tde_q;
    assign irq_ev[IRQ_RXF_BIT]  = cl_set[3];
    assign irq_ev[IRQ_ERR_BIT]  = ore_hit | fer_hit | per_hit;
    assign irq_ev[IRQ_TX_END_BIT] = tx_end & ~tx_end_q;

    // events win over the clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= IRQ_RESET;
        end else if (rd_acc & hit_istat) begin
            irq_stat <= irq_ev;
        end else begin
            irq_stat <= irq_stat | irq_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= IRQ_RESET;
        end else if (wr_acc & hit_imask) begin
            irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        prdata = ZERO_WORD;
        if (rd_acc) begin
            if (hit_status) begin
                prdata[7:0] = status;
            end else if (hit_istat) begin
                prdata[IRQ_W-1:0] = irq_stat;
            end else if (hit_imask) begin
                prdata[IRQ_W-1:0] = irq_mask;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_standby_init: assert property (
        standby |=> status == STATUS_RESET
    ) else $error("status not initialised on standby");
    chk_one_write_none: assert property (
        st_wr && pwdata[RDF_BIT] && !cl_flag[3] && !rx_clean && !init
        |=> !cl_flag[3]
    ) else $error("writing one set rx full");
    chk_unread_zero: assert property (
        st_wr && !pwdata[ORE_BIT] && cl_flag[2] && !cl_armed[2] && !init
        |=> cl_flag[2]
    ) else $error("overrun cleared without prior read");
    chk_tx_end_ro: assert property (
        st_wr && !init && transmit_enable && !tde_sw_clear && !tx_last_bit
        |=> tx_end == $past(tx_end)
    ) else $error("transmit end changed by write");
    chk_tde_disable: assert property (
        !transmit_enable && !init |=> cl_flag[4] && tx_end
    ) else $error("tx empty or end not set on disable");
    chk_overrun_keep: assert property (
        ore_hit && !init |=> cl_flag[2] && rx_holding_reg == $past(rx_holding_reg)
    ) else $error("overrun lost flag or replaced data");
    chk_err_no_full: assert property (
        (fer_hit || per_hit) && !init |=> !cl_flag[3] && rx_holding_reg == $past(rx_char)
    ) else $error("error char set full or was not loaded");
    chk_err_blocks: assert property (
        any_err && rx_done |=> rx_holding_reg == $past(rx_holding_reg)
    ) else $error("reception continued with error flag set");
    chk_tx_end_clear: assert property (
        tde_sw_clear && transmit_enable && !init && !tx_last_bit && !tx_load
        |=> !tx_end && !cl_flag[4]
    ) else $error("qualified clear missed tx empty or end");
    chk_mp_skip: assert property (
        rx_take && rx_skip |=> rx_holding_reg == $past(rx_holding_reg) && !multiproc_int_enable_clear
    ) else $error("character taken during mp wait");
    chk_irq_level: assert property (
        irq_ev[IRQ_RXF_BIT] && irq_mask[IRQ_RXF_BIT] && !(wr_acc && hit_imask)
        |=> irq
    ) else $error("irq missing for masked-in event");

    cov_overrun: cover property (cl_flag[3] ##[1:20] ore_hit);
    cov_tx_end_clear: cover property (st_rd && cl_flag[4] ##[1:5] tde_sw_clear);
    cov_mp_exit: cover property (rx_skip && rx_take ##[1:50] multiproc_int_enable_clear);
    cov_dma_read: cover property (cl_flag[3] && dma_rx_read);
endmodule : serial_status_flag_logic

// file: remote_serial_dev.sv
`timescale 1ns/1ps
// ****************************************
// far-end serial device, one char per request
// ****************************************
module remote_serial_dev (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // requests from the bench
    input  wire logic       req,
    input  wire logic [7:0] chr,
    input  wire logic       odd,
    input  wire logic       bad_par,
    input  wire logic       bad_stop,
    input  wire logic       rx_multiproc_bit,
    input  wire logic [1:0] lag,
    // character towards the receiver
    output logic            rx_done,
    output logic      [7:0] rx_char,
    output logic            rx_parity_bit,
    output logic            rx_stop_bit,
    output logic            rx_mp_bit
);
    logic       busy;
    logic [1:0] cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy          <= 1'b0;
            cnt           <= 2'h0;
            rx_done       <= 1'b0;
            rx_char       <= 8'h00;
            rx_parity_bit <= 1'b0;
            rx_stop_bit   <= 1'b1;
            rx_mp_bit     <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (req) begin
                busy <= 1'b1;
                cnt  <= lag;
            end else if (busy && cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else if (busy) begin
                busy          <= 1'b0;
                rx_done       <= 1'b1;
                rx_char       <= chr;
                rx_parity_bit <= ^chr ^ odd ^ bad_par;
                rx_stop_bit   <= ~bad_stop;
                rx_mp_bit     <= rx_multiproc_bit;
            end else begin
                // outside frames the lines carry no stale value
                rx_char       <= ~rx_char;
                rx_parity_bit <= ~rx_parity_bit;
                rx_stop_bit   <= ~rx_stop_bit;
                rx_mp_bit     <= ~rx_mp_bit;
            end
        end
    end
endmodule : remote_serial_dev

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import serial_status_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, standby;
    logic        transmit_enable, receive_enable, sync_mode, multiproc_format;
    logic        parity_enable, parity_odd, multiproc_int_enable, multiproc_int_enable_clear;
    logic        tx_load, tx_last_bit, tx_multiproc_bit, tx_blocked, rx_done;
    logic        rx_parity_bit, rx_stop_bit, rx_mp_bit, dma_rx_read, rx_blocked, irq;
    logic        p_req, p_bp, p_bs, p_mp, e, mpc;
    logic [1:0]  p_lag;
    logic [7:0]  rx_char, rx_holding_reg, p_chr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          n_fail, comparisons;

    serial_status_flag_logic dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .standby, .transmit_enable, .receive_enable,
        .sync_mode, .multiproc_format, .parity_enable, .parity_odd, .multiproc_int_enable,
        .multiproc_int_enable_clear, .tx_load, .tx_last_bit, .tx_multiproc_bit, .tx_blocked, .rx_done,
        .rx_char, .rx_parity_bit, .rx_stop_bit, .rx_mp_bit, .dma_rx_read, .rx_holding_reg,
        .rx_blocked, .irq);

    remote_serial_dev peer_u (.pclk, .presetn, .req(p_req), .chr(p_chr), .odd(parity_odd),
        .bad_par(p_bp), .bad_stop(p_bs), .rx_multiproc_bit(p_mp), .lag(p_lag), .rx_done, .rx_char,
        .rx_parity_bit, .rx_stop_bit, .rx_mp_bit);

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // ****************************************
    // access tasks
    // ****************************************
    task complete_run;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        if (pready !== 1'b1) begin
            n_fail++;
            complete_run;
        end
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd_stat(input logic [7:0] exp);
        apb(1'b0, STATUS_OFS, ZERO_WORD);
        chk(q[7:0], exp);
    endtask : rd_stat

    task settle;
        @(posedge pclk);
        #1;
    endtask : settle

    task pulse(input logic [2:0] p);
        @(posedge pclk);
        {tx_load, tx_last_bit, dma_rx_read} <= p;
        @(posedge pclk);
        {tx_load, tx_last_bit, dma_rx_read} <= 3'h0;
    endtask : pulse

    task send(input logic [7:0] c, input logic bp, input logic bs, input logic mp);
        int n;
        @(posedge pclk);
        {p_req, p_chr, p_bp, p_bs, p_mp} <= {1'b1, c, bp, bs, mp};
        p_lag <= p_lag + 2'h1;
        @(posedge pclk);
        p_req <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rx_done !== 1'b1 && n < 16);
        if (rx_done !== 1'b1) begin
            n_fail++;
            complete_run;
        end
        @(posedge pclk);
        mpc = multiproc_int_enable_clear;
    endtask : send

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, standby, receive_enable, sync_mode} = 7'h00;
        {multiproc_format, parity_odd, multiproc_int_enable, tx_load} = 4'h0;
        {tx_last_bit, dma_rx_read, p_req, p_bp, p_bs} = 5'h00;
        {transmit_enable, parity_enable, p_mp, p_lag} = 5'h18;
        paddr = 12'h000;
        pwdata = ZERO_WORD;
        p_chr = 8'h00;
        n_fail = 0;
        comparisons = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // transmit flags
        wr(STATUS_OFS, ZERO_WORD);
        rd_stat(8'h84);
        wr(STATUS_OFS, 32'h0000_00ff);
        rd_stat(8'h85);
        chk(8'(tx_multiproc_bit), 8'h01);
        wr(STATUS_OFS, ZERO_WORD);
        rd_stat(8'h00);
        pulse(3'h2);
        rd_stat(8'h00);
        pulse(3'h4);
        rd_stat(8'h80);
        pulse(3'h2);
        rd_stat(8'h84);
        wr(STATUS_OFS, ZERO_WORD);
        rd_stat(8'h00);
        @(posedge pclk) transmit_enable <= 1'b0;
        rd_stat(8'h84);
        // receive flags and interrupt
        apb(1'b0, IRQ_STAT_OFS, ZERO_WORD);
        @(posedge pclk) receive_enable <= 1'b1;
        send(8'ha5, 1'b0, 1'b0, 1'b0);
        settle;
        chk(8'(irq), 8'h00);
        chk(rx_holding_reg, 8'ha5);
        rd_stat(8'hc4);
        wr(IRQ_MASK_OFS, 32'h0000_0002);
        settle;
        chk(8'(irq), 8'h01);
        apb(1'b0, IRQ_STAT_OFS, ZERO_WORD);
        chk(q[7:0], 8'h02);
        settle;
        chk(8'(irq), 8'h00);
        send(8'h3c, 1'b0, 1'b0, 1'b0);
        rd_stat(8'he4);
        chk(rx_holding_reg, 8'ha5);
        chk(8'(rx_blocked), 8'h01);
        pulse(3'h1);
        send(8'h11, 1'b0, 1'b0, 1'b0);
        rd_stat(8'ha4);
        wr(STATUS_OFS, 32'h0000_00de);
        rd_stat(8'h84);
        send(8'h5a, 1'b0, 1'b1, 1'b0);
        chk(rx_holding_reg, 8'h5a);
        @(posedge pclk) receive_enable <= 1'b0;
        rd_stat(8'h94);
        @(posedge pclk) receive_enable <= 1'b1;
        wr(STATUS_OFS, 32'h0000_00ee);
        @(posedge pclk) parity_odd <= 1'b1;
        send(8'h66, 1'b1, 1'b0, 1'b0);
        chk(rx_holding_reg, 8'h66);
        rd_stat(8'h8c);
        wr(STATUS_OFS, 32'h0000_00f6);
        send(8'h77, 1'b0, 1'b0, 1'b0);
        rd_stat(8'hc4);
        pulse(3'h1);
        @(posedge pclk) parity_enable <= 1'b0;
        send(8'h21, 1'b1, 1'b0, 1'b0);
        rd_stat(8'hc4);
        pulse(3'h1);
        // multiprocessor format
        @(posedge pclk) {multiproc_format, multiproc_int_enable} <= 2'h3;
        send(8'h12, 1'b0, 1'b0, 1'b0);
        rd_stat(8'h84);
        chk(rx_holding_reg, 8'h21);
        send(8'h34, 1'b0, 1'b0, 1'b1);
        chk(8'(mpc), 8'h01);
        @(posedge pclk) multiproc_int_enable <= 1'b0;
        rd_stat(8'hc6);
        chk(rx_holding_reg, 8'h34);
        @(posedge pclk) receive_enable <= 1'b0;
        send(8'h56, 1'b0, 1'b0, 1'b0);
        rd_stat(8'hc6);
        // synchronous mode, standby, unmapped access
        @(posedge pclk) {receive_enable, sync_mode} <= 2'h3;
        send(8'h9a, 1'b0, 1'b0, 1'b0);
        settle;
        chk(8'(tx_blocked), 8'h01);
        wr(STATUS_OFS, ZERO_WORD);
        rd_stat(8'ha6);
        @(posedge pclk) standby <= 1'b1;
        @(posedge pclk) standby <= 1'b0;
        rd_stat(8'h84);
        chk(8'(tx_blocked), 8'h00);
        wr(12'h00c, ZERO_WORD);
        chk({7'h00, e}, 8'h01);
        rd_stat(8'h84);
        complete_run;
    end
endmodule : testbench
